/* rtl/dec_debug_entry_control.sv */
// Purpose: debug entry control of the core: stop, acknowledge, isolate, inject, resume
// Assumes: pipeline status and comparator outputs share sys_clk; debug request is asynchronous
// Notes: one clock edge stands for the phase-2 latch point of the core's two-phase clock
// Notes on behaviour
// RULE_01: the core stops into debug state on a fetch breakpoint, a data watchpoint or a debug request.
// RULE_02: three inputs ask for entry and one acknowledge output tells the system the core is in debug.
// RULE_03: the breakpoint indication is sampled in the cycle right after an instruction is latched; the code samples it in the latch cycle, with fetch_latch.
// RULE_04: the outside breakpoint input is ORed with the internal one and the result drives control.
// RULE_05: a breakpointed instruction still reaches execute but all its state updates are suppressed.
// RULE_06: writes of older instructions finish normally before debug state is entered.
// RULE_07: the entry sequence decodes in the same cycle that the breakpointed instruction executes.
// RULE_08: a breakpoint latched with an instruction starts the entry sequence.
// RULE_09: in debug state the core detaches from memory so the rest of the system runs on.
// RULE_10: in debug state instructions from the serial test port are fed into the pipeline.
// RULE_11: after examination the core may be restored and resume normal execution.
// RULE_12: a prefetch abort on a breakpointed instruction wins and the breakpoint is dropped.
// RULE_13: an interrupt meeting a breakpointed instruction is taken and the instruction is discarded.
// RULE_14: a synchronised debug request beats pending interrupts and enters once older stages drain.
// RULE_15: in debug state both memory interfaces show internal cycles and aborts and interrupts are ignored.
// RULE_16: acknowledge rises on entry, holds through debug state and drops only on resume.
`timescale 1ns/1ps
module dec_debug_entry_control
#(
   parameter int INSTR_W = dec_pkg::DEC_INSTR_W
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ext_breakpoint_in,
   input wire logic int_breakpoint_in,
   input wire logic ext_watchpoint_in,
   input wire logic ext_debug_request,
   input wire dec_pkg::dec_pipe_in_t pipe_in,
   input wire logic scan_instr_valid,
   input wire logic [INSTR_W-1:0] scan_instr,
   input wire logic debug_restart,
   output logic debug_acknowledge,
   output logic exec_suppress,
   output logic issue_hold,
   output logic decode_discard,
   output logic irq_block,
   output logic abort_block,
   output dec_pkg::dec_mem_ctl_t mem_ctl,
   output logic [1:0] entry_cause,
   output logic inject_valid,
   output logic [INSTR_W-1:0] inject_instr
);
   import dec_pkg::*;

   dec_ctl_t ctl_reg;
   dec_ctl_t ctl_next;
   logic req_sync;
   logic bkpt_any;

   // the request pin is asynchronous to the core clock
   dec_sync2 u_req_sync
   (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(ext_debug_request),
      .sync_out(req_sync)
   );

   function automatic dec_ctl_t enter_debug(input dec_ctl_t c);
      dec_ctl_t r;
      r = c;
      r.state = dec_st_debug;
      r.ack = 1'b1; // see RULE_16
      r.mem_internal = 1'b1; // see RULE_09
      r.irq_block = 1'b1; // see RULE_15
      r.abort_block = 1'b1; // see RULE_15
      r.suppress = 1'b0;
      r.hold = 1'b1;
      r.req_pend = 1'b0;
      r.watch_pend = 1'b0;
      r.bkpt_dec = 1'b0;
      return r;
   endfunction

   always_comb
   begin
      bkpt_any = ext_breakpoint_in | int_breakpoint_in; // see RULE_04
      ctl_next = ctl_reg;
      ctl_next.discard = 1'b0;
      ctl_next.inject_valid = 1'b0;

      case (ctl_reg.state)
         dec_st_run:
         begin
            // breakpoint travels with the instruction held in decode
            if (pipe_in.fetch_latch)
            begin
               ctl_next.bkpt_dec = bkpt_any & ~pipe_in.prefetch_abort; // see RULE_03, see RULE_12
            end
            else if (pipe_in.decode_advance)
            begin
               ctl_next.bkpt_dec = 1'b0;
            end

            if (ext_watchpoint_in)
            begin
               ctl_next.watch_pend = 1'b1; // see RULE_01
               ctl_next.watch_cnt = 2'h0;
            end
            else if (ctl_reg.watch_pend && pipe_in.exec_retire)
            begin
               ctl_next.watch_cnt = ctl_reg.watch_cnt + 2'h1;
            end

            if (req_sync)
            begin
               ctl_next.req_pend = 1'b1; // see RULE_14
            end
            ctl_next.irq_block = req_sync | ctl_reg.req_pend; // see RULE_14

            if (ctl_reg.req_pend)
            begin
               // no further issue while the executing instruction finishes
               ctl_next.hold = 1'b1; // see RULE_14
               ctl_next.irq_block = 1'b1;
               ctl_next.cause = DEC_CAUSE_REQ;
               ctl_next.state = dec_st_drain;
            end
            else if (ctl_reg.bkpt_dec && pipe_in.decode_advance && pipe_in.irq_pending)
            begin
               // interrupt wins; the instruction is refetched after service
               ctl_next.discard = 1'b1; // see RULE_13
               ctl_next.bkpt_dec = 1'b0;
            end
            else if (ctl_reg.bkpt_dec && pipe_in.decode_advance)
            begin
               // breakpointed instruction enters execute with updates blocked
               ctl_next.suppress = 1'b1; // see RULE_05
               ctl_next.hold = 1'b1; // see RULE_07, see RULE_08
               ctl_next.irq_block = 1'b1;
               ctl_next.cause = DEC_CAUSE_BKPT;
               ctl_next.state = dec_st_drain;
            end
            else if (ctl_reg.watch_pend && !ext_watchpoint_in &&
                     (ctl_reg.watch_cnt >= DEC_WATCH_RETIRE_CNT ||
                      (pipe_in.exec_retire && ctl_reg.watch_cnt + 2'h1 >= DEC_WATCH_RETIRE_CNT)))
            begin
               // imprecise entry: the next instruction is allowed to complete
               ctl_next.hold = 1'b1; // see RULE_01
               ctl_next.irq_block = 1'b1;
               ctl_next.cause = DEC_CAUSE_WATCH;
               ctl_next.state = dec_st_drain;
            end
         end

         dec_st_drain:
         begin
            // older memory and write stages finish before isolation
            ctl_next.req_pend = 1'b0;
            if (!pipe_in.older_busy)
            begin
               ctl_next = enter_debug(ctl_reg); // see RULE_06, see RULE_14
            end
         end

         dec_st_debug:
         begin
            ctl_next.ack = 1'b1; // see RULE_16
            // instructions come from the serial port, not the data bus
            if (scan_instr_valid)
            begin
               ctl_next.inject_valid = 1'b1; // see RULE_10
               ctl_next.inject_instr = scan_instr;
            end
            if (debug_restart)
            begin
               ctl_next.state = dec_st_exit; // see RULE_11
            end
         end

         dec_st_exit:
         begin
            // let the last injected instruction drain before memory is reconnected
            if (!pipe_in.older_busy)
            begin
               ctl_next.state = dec_st_run; // see RULE_11
               ctl_next.ack = 1'b0; // see RULE_16
               ctl_next.mem_internal = 1'b0;
               ctl_next.irq_block = 1'b0;
               ctl_next.abort_block = 1'b0;
               ctl_next.hold = 1'b0;
               ctl_next.cause = DEC_CAUSE_NONE;
               ctl_next.watch_cnt = 2'h0;
            end
         end

         default:
         begin
            ctl_next.state = dec_st_run;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ctl_reg.state <= dec_st_run;
         ctl_reg.bkpt_dec <= 1'b0;
         ctl_reg.watch_pend <= 1'b0;
         ctl_reg.watch_cnt <= 2'h0;
         ctl_reg.req_pend <= 1'b0;
         ctl_reg.ack <= 1'b0;
         ctl_reg.suppress <= 1'b0;
         ctl_reg.hold <= 1'b0;
         ctl_reg.mem_internal <= 1'b0;
         ctl_reg.irq_block <= 1'b0;
         ctl_reg.abort_block <= 1'b0;
         ctl_reg.discard <= 1'b0;
         ctl_reg.cause <= DEC_CAUSE_NONE;
         ctl_reg.inject_valid <= 1'b0;
         ctl_reg.inject_instr <= '0;
      end
      else
      begin
         ctl_reg <= ctl_next;
      end
   end

   assign debug_acknowledge = ctl_reg.ack; // see RULE_02
   assign exec_suppress = ctl_reg.suppress;
   assign issue_hold = ctl_reg.hold;
   assign decode_discard = ctl_reg.discard;
   assign irq_block = ctl_reg.irq_block;
   assign abort_block = ctl_reg.abort_block;
   assign mem_ctl.instr_internal = ctl_reg.mem_internal; // see RULE_15
   assign mem_ctl.data_internal = ctl_reg.mem_internal; // see RULE_15
   assign entry_cause = ctl_reg.cause;
   assign inject_valid = ctl_reg.inject_valid;
   assign inject_instr = ctl_reg.inject_instr;

endmodule // dec_debug_entry_control

/* rtl/dec_pkg.sv */
// Purpose: shared types and constants of the debug entry control block
// Assumes: one core clock, synchronous active-high reset
// Notes: state machine codes are one-hot
package dec_pkg;

   localparam int DEC_INSTR_W = 32;

   // entry cause codes shown on the cause output
   localparam logic [1:0] DEC_CAUSE_NONE = 2'h0;
   localparam logic [1:0] DEC_CAUSE_BKPT = 2'h1;
   localparam logic [1:0] DEC_CAUSE_WATCH = 2'h2;
   localparam logic [1:0] DEC_CAUSE_REQ = 2'h3;

   // instructions the watchpointed access lets through before entry
   localparam logic [1:0] DEC_WATCH_RETIRE_CNT = 2'h1;

   // synchroniser reset level
   localparam logic DEC_SYNC_RST = 1'b0;

   typedef enum logic [3:0]
   {
      dec_st_run = 4'h1,
      dec_st_drain = 4'h2,
      dec_st_debug = 4'h4,
      dec_st_exit = 4'h8
   } dec_state_t;

   // pipeline status from the core control logic, same clock
   typedef struct packed
   {
      logic fetch_latch;
      logic prefetch_abort;
      logic decode_advance;
      logic exec_retire;
      logic older_busy;
      logic irq_pending;
   } dec_pipe_in_t;

   // memory interface cycle type overrides
   typedef struct packed
   {
      logic instr_internal;
      logic data_internal;
   } dec_mem_ctl_t;

   typedef struct packed
   {
      logic stage1;
      logic stage2;
   } dec_sync_t;

   typedef struct packed
   {
      dec_state_t state;
      logic bkpt_dec;
      logic watch_pend;
      logic [1:0] watch_cnt;
      logic req_pend;
      logic ack;
      logic suppress;
      logic hold;
      logic mem_internal;
      logic irq_block;
      logic abort_block;
      logic discard;
      logic [1:0] cause;
      logic inject_valid;
      logic [DEC_INSTR_W-1:0] inject_instr;
   } dec_ctl_t;

endpackage

/* rtl/dec_sync2.sv */
// Purpose: two-flop synchroniser for one asynchronous level
// Assumes: input may change at any time relative to sys_clk
// Notes: only the second flop is visible outside
`timescale 1ns/1ps
module dec_sync2
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic async_in,
   output logic sync_out
);
   import dec_pkg::*;

   dec_sync_t sync_reg;
   dec_sync_t sync_next;

   always_comb
   begin
      sync_next = sync_reg;
      sync_next.stage1 = async_in;
      // first stage feeds nothing but the second
      sync_next.stage2 = sync_reg.stage1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sync_reg.stage1 <= DEC_SYNC_RST;
         sync_reg.stage2 <= DEC_SYNC_RST;
      end
      else
      begin
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg.stage2;

endmodule // dec_sync2

/* verification/dec_checker.sv */
// Purpose: port assertions for debug entry control
// Assumes: one clock, sync active-high reset
// Notes: bound to the design top after the module
`timescale 1ns/1ps
module dec_checker
#(
   parameter int INSTR_W = 32
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ext_breakpoint_in,
   input wire logic int_breakpoint_in,
   input wire logic ext_watchpoint_in,
   input wire logic ext_debug_request,
   input wire dec_pkg::dec_pipe_in_t pipe_in,
   input wire logic scan_instr_valid,
   input wire logic [INSTR_W-1:0] scan_instr,
   input wire logic debug_restart,
   input wire logic debug_acknowledge,
   input wire logic exec_suppress,
   input wire logic issue_hold,
   input wire logic decode_discard,
   input wire logic irq_block,
   input wire logic abort_block,
   input wire dec_pkg::dec_mem_ctl_t mem_ctl,
   input wire logic [1:0] entry_cause,
   input wire logic inject_valid,
   input wire logic [INSTR_W-1:0] inject_instr
);
   import dec_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire bk = ext_breakpoint_in | int_breakpoint_in;
   wire idle = !issue_hold && !debug_acknowledge;
   sequence s_bkpt;
      pipe_in.fetch_latch && bk && !pipe_in.prefetch_abort && idle ##1 pipe_in.decode_advance;
   endsequence
   bkpt_entry_a:
   assert property (s_bkpt ##0 !pipe_in.irq_pending |=> exec_suppress && issue_hold && entry_cause == DEC_CAUSE_BKPT)
      else $error("breakpoint did not start entry");
   abort_wins_a:
   assert property (pipe_in.fetch_latch && pipe_in.prefetch_abort && idle ##1 pipe_in.decode_advance
      |=> !exec_suppress && !issue_hold) else $error("breakpoint taken despite prefetch abort");
   irq_discard_a:
   assert property (s_bkpt ##0 pipe_in.irq_pending |=> decode_discard && !exec_suppress)
      else $error("interrupt did not discard breakpoint");
   req_sync_a:
   assert property ($rose(ext_debug_request) && idle |-> ##3 irq_block) else $error("request not blocking interrupts");
   ack_entry_a:
   assert property ($rose(debug_acknowledge) |-> $past(issue_hold) && !$past(pipe_in.older_busy))
      else $error("acknowledge before older writes done");
   mem_isolate_a:
   assert property (debug_acknowledge |-> mem_ctl.instr_internal && mem_ctl.data_internal && irq_block && abort_block)
      else $error("core not isolated in debug");
   scan_inject_a:
   assert property (debug_acknowledge && !debug_restart && scan_instr_valid |=> inject_valid
      && inject_instr == $past(scan_instr)) else $error("scan instruction not injected");
   no_inject_a:
   assert property (!debug_acknowledge |=> !inject_valid) else $error("injection outside debug");
   exit_clear_a:
   assert property (debug_restart && debug_acknowledge ##1 !pipe_in.older_busy |=> !debug_acknowledge
      && !issue_hold && !mem_ctl.data_internal) else $error("exit did not resume");
   cover property (s_bkpt ##1 exec_suppress);
   cover property ($rose(debug_acknowledge) ##0 entry_cause == DEC_CAUSE_REQ);
   cover property (inject_valid);
endmodule // dec_checker

bind dec_debug_entry_control dec_checker #(.INSTR_W(INSTR_W)) chk_u (.sys_clk, .sys_rst, .ext_breakpoint_in,
   .int_breakpoint_in, .ext_watchpoint_in, .ext_debug_request, .pipe_in, .scan_instr_valid, .scan_instr,
   .debug_restart, .debug_acknowledge, .exec_suppress, .issue_hold, .decode_discard, .irq_block, .abort_block,
   .mem_ctl, .entry_cause, .inject_valid, .inject_instr);

/* verification/dec_partner.sv */
// Purpose: outside comparators and debug request source
// Assumes: commands come from the bench just after an edge
// Notes: breakpoint answers inside the latch cycle
`timescale 1ns/1ps
module dec_partner
(
   input wire logic sys_clk,
   input wire logic fetch_latch,
   input wire logic debug_acknowledge,
   input wire logic bkpt_arm,
   input wire logic watch_go,
   input wire logic req_go,
   output logic ext_breakpoint_in,
   output logic ext_watchpoint_in,
   output logic ext_debug_request
);
   assign ext_breakpoint_in = bkpt_arm & fetch_latch;
   assign ext_watchpoint_in = watch_go;
   initial ext_debug_request = 1'b0;
   // held until seen, a short glitch could be lost in sync
   always @(posedge sys_clk)
   begin
      if (debug_acknowledge)
         ext_debug_request <= #1 1'b0;
      else if (req_go)
         ext_debug_request <= #1 1'b1;
   end
endmodule // dec_partner

/* verification/dec_tb.sv */
// Purpose: self-checking bench for debug entry control
// Assumes: inputs change 1 ns after the rising edge
// Notes: partner model drives the outside debug inputs
`timescale 1ns/1ps
module tb;
   import dec_pkg::*;
   logic sys_clk = 0, sys_rst = 1, int_breakpoint_in = 0, scan_instr_valid = 0, debug_restart = 0;
   logic bkpt_arm = 0, watch_go = 0, req_go = 0, ext_breakpoint_in, ext_watchpoint_in, ext_debug_request;
   logic debug_acknowledge, exec_suppress, issue_hold, decode_discard, irq_block, abort_block, inject_valid;
   logic [31:0] scan_instr = 32'h0, inject_instr;
   logic [1:0] entry_cause;
   dec_pipe_in_t pipe_in = '0;
   dec_mem_ctl_t mem_ctl;
   int errors = 0, checked = 0;
   dec_debug_entry_control dut_u (.sys_clk, .sys_rst, .ext_breakpoint_in, .int_breakpoint_in, .ext_watchpoint_in,
      .ext_debug_request, .pipe_in, .scan_instr_valid, .scan_instr, .debug_restart, .debug_acknowledge,
      .exec_suppress, .issue_hold, .decode_discard, .irq_block, .abort_block, .mem_ctl, .entry_cause,
      .inject_valid, .inject_instr);
   dec_partner prt_u (.sys_clk, .fetch_latch(pipe_in.fetch_latch), .debug_acknowledge, .bkpt_arm, .watch_go,
      .req_go, .ext_breakpoint_in, .ext_watchpoint_in, .ext_debug_request);
   initial
   begin
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic step(int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_ack(logic lvl);
      for (int i = 0; i < 20 && debug_acknowledge !== lvl; i++)
         step();
      chk("ack wait", debug_acknowledge, lvl);
      if (debug_acknowledge !== lvl)
         finish_test();
   endtask
   task automatic fetch(logic ext, logic intl, logic pa, logic irq);
      bkpt_arm = ext;
      int_breakpoint_in = intl;
      pipe_in.fetch_latch = 1;
      pipe_in.prefetch_abort = pa;
      step();
      {bkpt_arm, int_breakpoint_in, pipe_in.fetch_latch, pipe_in.prefetch_abort} = '0;
      pipe_in.decode_advance = 1;
      pipe_in.irq_pending = irq;
      step();
      pipe_in.decode_advance = 0;
      pipe_in.irq_pending = 0;
   endtask
   task automatic leave();
      debug_restart = 1;
      step();
      debug_restart = 0;
      wait_ack(0);
      chk("released", {mem_ctl, issue_hold, irq_block, abort_block}, 0);
   endtask
   task automatic t_bkpt(logic ext);
      pipe_in.older_busy = 1;
      fetch(ext, !ext, 0, 0);
      chk("suppress", {exec_suppress, issue_hold, entry_cause}, {2'h3, DEC_CAUSE_BKPT});
      step(2);
      chk("ack busy", debug_acknowledge, 0);
      pipe_in.older_busy = 0;
      wait_ack(1);
      chk("isolated", {mem_ctl, irq_block, abort_block, exec_suppress}, 5'h1e);
      scan_instr = {16'h5a0f, 15'h0, ext};
      scan_instr_valid = 1;
      step();
      scan_instr_valid = 0;
      chk("inject valid", inject_valid, 1);
      chk("inject instr", inject_instr, scan_instr);
      leave();
   endtask
   task automatic t_refuse();
      fetch(1, 0, 1, 0);
      chk("abort wins", {exec_suppress, issue_hold}, 0);
      fetch(0, 1, 0, 1);
      chk("irq discard", {decode_discard, exec_suppress, issue_hold}, 3'h4);
      scan_instr_valid = 1;
      step();
      scan_instr_valid = 0;
      chk("no inject", inject_valid, 0);
      step(3);
      chk("no entry", debug_acknowledge, 0);
   endtask
   task automatic t_watch();
      watch_go = 1;
      step();
      watch_go = 0;
      pipe_in.exec_retire = 1;
      step();
      pipe_in.exec_retire = 0;
      wait_ack(1);
      chk("watch cause", entry_cause, DEC_CAUSE_WATCH);
      leave();
   endtask
   task automatic t_req();
      pipe_in.irq_pending = 1;
      req_go = 1;
      step();
      req_go = 0;
      wait_ack(1);
      chk("req cause", {entry_cause, irq_block}, {DEC_CAUSE_REQ, 1'b1});
      pipe_in.irq_pending = 0;
      step(2);
      chk("ack held", debug_acknowledge, 1);
      leave();
   endtask
   initial
   begin
      step(10);
      sys_rst = 0;
      chk("reset", {debug_acknowledge, mem_ctl, issue_hold, entry_cause}, 0);
      t_bkpt(1);
      t_bkpt(0);
      t_refuse();
      t_watch();
      t_req();
      finish_test();
   end
endmodule // tb
